// >>> verilog/lcb_memory_access.sv
// Purpose: Indexed display memory window, LCD clock chain, blink timing and interrupt
// Assumes: Register strobes and watch timer level are synchronous to clk_sys
// Notes: Frame end is taken as the end of the waveform pattern
//
// Added by the designer: the address-and-strobe port.
`timescale 1ns/100ps
`include "lcb_defs.svh"

module lcb_memory_access (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [11:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [7:0] regRdata,
    input wire logic watchTimerOutput,
    input wire logic [3:0] segByteAddr,
    output logic [7:0] segByte,
    output logic frameEnd,
    output logic blinkOff,
    output logic bankBActive,
    output logic irq
);

    // Software-visible registers
    logic [4:0] index_reg;
    lcb_pkg::lcb_clk_cfg_s clockCfg_reg;
    lcb_pkg::lcb_blink_cfg_s blinkCfg_reg;
    lcb_pkg::lcb_blink_cfg_s blinkActive_reg; // Copy that the blink logic obeys
    lcb_pkg::lcb_dm_e dmSelect_reg;
    logic irqSourceSelect_reg; // 0 frame end, 1 blink or bank switch
    logic [1:0] status_reg;
    logic [1:0] mask_reg;
    logic [7:0] regRdata_reg;
    logic [7:0] memory [0:2*`LCB_BANK_BYTES-1]; // Bank A then bank B

    // Timing state
    logic wtoPrev_reg;
    logic blinkOff_reg;
    logic bankB_reg;
    logic frameEnd_reg;
    logic [7:0] segByte_reg;
    logic irq_reg;

    // Decode of the strobes
    logic portalHit;
    logic indexValid;
    logic [4:0] memIdx;
    logic [4:0] index_next;
    logic [7:0] portalByte;
    logic [7:0] readMux;

    assign portalHit = (regWr || regRd) && (regAddr == `LCB_ADDR_PORTAL);
    // Low nibble above the last byte is a reserved hole
    assign indexValid = (index_reg[3:0] <= `LCB_BANK_LAST_OFS);
    assign memIdx = index_reg[4] ? (5'(index_reg[3:0]) + 5'(`LCB_BANK_BYTES)) : 5'(index_reg[3:0]);
    assign portalByte = indexValid ? memory[memIdx] : `LCB_RESET_BYTE;

    // Auto-increment with the two bank wraps
    always_comb begin
        if (index_reg == `LCB_BANK_A_LAST) begin
            index_next = `LCB_RESET_INDEX;
        end else if (index_reg == `LCB_BANK_B_LAST) begin
            index_next = `LCB_BANK_B_FIRST;
        end else begin
            index_next = index_reg + 5'h01;
        end
    end

    // Index register; upper bits are not stored and read back as zero
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            index_reg <= `LCB_RESET_INDEX;
        end else if (portalHit) begin
            index_reg <= index_next;
        end else if (regWr && regAddr == `LCB_ADDR_INDEX) begin
            index_reg <= regWdata[`LCB_INDEX_MSB:0];
        end
    end

    // Display memory; writes to reserved indexes are dropped
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            for (int i = 0; i < 2*`LCB_BANK_BYTES; i++) begin
                memory[i] <= `LCB_RESET_BYTE;
            end
        end else if (regWr && portalHit && indexValid) begin
            memory[memIdx] <= regWdata;
        end
    end

    // Clock, blink, mode and mask registers
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            clockCfg_reg <= lcb_pkg::lcb_clk_cfg_s'(`LCB_RESET_BYTE);
            blinkCfg_reg <= lcb_pkg::lcb_blink_cfg_s'(`LCB_RESET_BYTE);
            dmSelect_reg <= lcb_pkg::LCB_DM_BANK_A;
            irqSourceSelect_reg <= 1'b0;
            mask_reg <= 2'h0;
        end else if (regWr) begin
            case (regAddr)
                `LCB_ADDR_CLOCK: clockCfg_reg <= lcb_pkg::lcb_clk_cfg_s'(regWdata);
                // Reserved bit is stored as written
                `LCB_ADDR_BLINK: blinkCfg_reg <= lcb_pkg::lcb_blink_cfg_s'(regWdata);
                `LCB_ADDR_MODE: begin
                    dmSelect_reg <= lcb_pkg::lcb_dm_e'(regWdata[1:0]);
                    irqSourceSelect_reg <= regWdata[`LCB_MODE_INTERRUPT_SOURCE_SELECT_BIT];
                end
                `LCB_ADDR_MASK: mask_reg <= regWdata[1:0];
                default: begin
                    // Other addresses hold nothing here
                end
            endcase
        end
    end

    // Read mux, sampled at the strobe and presented the next cycle
    always_comb begin
        case (regAddr)
            `LCB_ADDR_INDEX: readMux = {3'h0, index_reg};
            `LCB_ADDR_PORTAL: readMux = portalByte;
            `LCB_ADDR_CLOCK: readMux = clockCfg_reg;
            `LCB_ADDR_BLINK: readMux = blinkCfg_reg;
            `LCB_ADDR_MODE: readMux = {5'h00, irqSourceSelect_reg, dmSelect_reg};
            `LCB_ADDR_STATUS: readMux = {6'h00, status_reg};
            `LCB_ADDR_MASK: readMux = {6'h00, mask_reg};
            default: readMux = `LCB_RESET_BYTE; // Unmapped reads as zero
        endcase
    end

    // Read data register
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            regRdata_reg <= `LCB_RESET_BYTE;
        end else begin
            regRdata_reg <= regRd ? readMux : `LCB_RESET_BYTE;
        end
    end

    // Clock chain: source, prescaler, frame divider, blink divider
    logic srcTick;
    logic prescaleTick;
    logic frameTick;
    logic blinkTick;
    logic [6:0] prescaleLimit;
    logic [6:0] frameLimit;
    logic [6:0] blinkLimit;

    // Watch timer rising edge; input is synchronous so no synchroniser
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            wtoPrev_reg <= 1'b0;
        end else begin
            wtoPrev_reg <= watchTimerOutput;
        end
    end

    assign srcTick = clockCfg_reg.clockSourceSelect ? (watchTimerOutput && !wtoPrev_reg) : 1'b1;

    // Reserved prescaler codes are clamped to the largest ratio
    assign prescaleLimit = 7'h01 << ((clockCfg_reg.prescaleCode > `LCB_PRESCALE_MAX) ?
                           `LCB_PRESCALE_MAX : clockCfg_reg.prescaleCode);

    // Codes up to six step by one from eight, then by two
    assign frameLimit = (clockCfg_reg.frameDividerCode < 4'h7) ?
                        (7'h08 + 7'(clockCfg_reg.frameDividerCode)) :
                        (7'(clockCfg_reg.frameDividerCode) * 7'h02 + 7'h02);

    // Blink ratio table is irregular between twenty and thirty-two
    always_comb begin
        case (blinkActive_reg.blinkDividerCode)
            5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06:
                blinkLimit = 7'(blinkActive_reg.blinkDividerCode) + 7'h02;
            5'h07, 5'h08, 5'h09, 5'h0a, 5'h0b, 5'h0c:
                blinkLimit = 7'(blinkActive_reg.blinkDividerCode) * 7'h02 - 7'h04;
            5'h0d: blinkLimit = 7'h18;
            5'h0e: blinkLimit = 7'h1c;
            default: blinkLimit = 7'(blinkActive_reg.blinkDividerCode) * 7'h02 + 7'h02;
        endcase
    end

    // Three identical counters, each stepped by the stage before it
    lcb_tick_divider #(.W(7)) uPrescale (
        .clk_sys(clk_sys),
        .rst(rst),
        .step(srcTick),
        .limit(prescaleLimit),
        .tick(prescaleTick)
    );

    lcb_tick_divider #(.W(7)) uFrame (
        .clk_sys(clk_sys),
        .rst(rst),
        .step(prescaleTick),
        .limit(frameLimit),
        .tick(frameTick)
    );

    lcb_tick_divider #(.W(7)) uBlink (
        .clk_sys(clk_sys),
        .rst(rst),
        .step(frameTick),
        .limit(blinkLimit),
        .tick(blinkTick)
    );

    // Blink settings move only at frame end to keep zero DC on the glass
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            blinkActive_reg <= lcb_pkg::lcb_blink_cfg_s'(`LCB_RESET_BYTE);
        end else if (frameTick) begin
            blinkActive_reg <= blinkCfg_reg;
        end
    end

    // Blink selection is overridden while banks alternate
    lcb_pkg::lcb_blink_e effBlink;
    logic alternate;
    logic blinkEvent;
    assign alternate = dmSelect_reg[1];
    assign effBlink = alternate ? lcb_pkg::LCB_BLINK_NONE : blinkActive_reg.blinkSelect;
    // Blink start is the entry into the off phase
    assign blinkEvent = blinkTick && (alternate ? !bankB_reg :
                        (effBlink != lcb_pkg::LCB_BLINK_NONE && !blinkOff_reg));

    // Blink phase
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            blinkOff_reg <= 1'b0;
        end else if (effBlink == lcb_pkg::LCB_BLINK_NONE) begin
            blinkOff_reg <= 1'b0;
        end else if (blinkTick) begin
            blinkOff_reg <= !blinkOff_reg;
        end
    end

    // Bank source; alternation paced by the blink divider
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            bankB_reg <= 1'b0;
        end else if (alternate) begin
            if (blinkTick) begin
                bankB_reg <= !bankB_reg;
            end
        end else begin
            bankB_reg <= (dmSelect_reg == lcb_pkg::LCB_DM_BANK_B);
        end
    end

    // Segment byte for the waveform generator, with blink masking
    logic [4:0] segIdx;
    logic [7:0] segRaw;
    assign segIdx = bankB_reg ? (5'(segByteAddr) + 5'(`LCB_BANK_BYTES)) : 5'(segByteAddr);
    assign segRaw = (segByteAddr <= `LCB_BANK_LAST_OFS) ? memory[segIdx] : `LCB_RESET_BYTE;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            segByte_reg <= `LCB_RESET_BYTE;
        end else if (!blinkOff_reg) begin
            segByte_reg <= segRaw;
        end else begin
            case (effBlink)
                // Segment line 0 sits in byte 0, commons 0 to 3 in bits 0 to 3
                lcb_pkg::LCB_BLINK_ONE: segByte_reg <= (segByteAddr == 4'h0) ? (segRaw & 8'hfe) : segRaw;
                lcb_pkg::LCB_BLINK_COLUMN: segByte_reg <= (segByteAddr == 4'h0) ? (segRaw & 8'hf0) : segRaw;
                lcb_pkg::LCB_BLINK_ALL: segByte_reg <= `LCB_RESET_BYTE;
                default: segByte_reg <= segRaw;
            endcase
        end
    end

    // Sticky status, write one to clear; a new event beats the clear
    logic [1:0] statusSet;
    logic [1:0] statusClr;
    assign statusSet = {blinkEvent, frameTick};
    assign statusClr = (regWr && regAddr == `LCB_ADDR_STATUS) ? regWdata[1:0] : 2'h0;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            status_reg <= 2'h0;
        end else begin
            status_reg <= (status_reg & ~statusClr) | statusSet;
        end
    end

    // Interrupt: only the chosen source counts, then the mask
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            irq_reg <= 1'b0;
            frameEnd_reg <= 1'b0;
        end else begin
            irq_reg <= |(status_reg & mask_reg & (irqSourceSelect_reg ? 2'h2 : 2'h1));
            frameEnd_reg <= frameTick;
        end
    end

    assign regRdata = regRdata_reg;
    assign segByte = segByte_reg;
    assign frameEnd = frameEnd_reg;
    assign blinkOff = blinkOff_reg;
    assign bankBActive = bankB_reg;
    assign irq = irq_reg;

    // Checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    a_index_advance: assert property (portalHit && index_reg != `LCB_BANK_A_LAST && index_reg != `LCB_BANK_B_LAST
        |=> index_reg == $past(index_reg) + 5'h01) else $error("index did not advance");
    a_wrap_bank_a: assert property (portalHit && index_reg == `LCB_BANK_A_LAST
        |=> index_reg == 5'h00) else $error("bank A wrap wrong");
    a_wrap_bank_b: assert property (portalHit && index_reg == `LCB_BANK_B_LAST
        |=> index_reg == 5'h10) else $error("bank B wrap wrong");
    a_reserved_read: assert property (regRd && portalHit && !indexValid
        |=> regRdata == 8'h00) else $error("reserved index read not zero");
    a_portal_read: assert property (regRd && portalHit
        |=> regRdata == $past(portalByte)) else $error("portal read wrong byte");
    a_source_gate: assert property (clockCfg_reg.clockSourceSelect && !(watchTimerOutput && !wtoPrev_reg)
        |-> !prescaleTick) else $error("tick without watch timer edge");
    a_prescale_one: assert property (!clockCfg_reg.clockSourceSelect && clockCfg_reg.prescaleCode == 3'h0
        |-> prescaleTick) else $error("divide by one missed tick");
    a_frame_spacing: assert property (frameTick && clockCfg_reg == 8'h00 ##1 clockCfg_reg == 8'h00 [*7]
        |-> !frameTick) else $error("frame came early");
    a_blink_defer: assert property ($changed(blinkActive_reg)
        |-> $past(frameTick)) else $error("blink config moved mid-frame");
    a_blink_limit: assert property (blinkActive_reg.blinkDividerCode == 5'h0d
        |-> blinkLimit == 7'h18) else $error("blink ratio wrong");
    a_blink_ignored: assert property (alternate [*2] |-> !blinkOff_reg) else $error("blink while alternating");
    a_blink_all: assert property (blinkOff_reg && effBlink == lcb_pkg::LCB_BLINK_ALL
        |=> segByte_reg == 8'h00) else $error("all-blink not blank");
    a_blink_event: assert property (blinkEvent |=> status_reg[1]) else $error("blink event lost");
    a_bank_switch: assert property (alternate && blinkTick && !bankB_reg
        |=> bankB_reg && status_reg[1]) else $error("bank switch wrong");
    a_chain_order: assert property (blinkTick |-> frameTick && prescaleTick) else $error("chain broken");
    a_reset_clear: assert property (disable iff (1'b0) rst |=> index_reg == 5'h00 && clockCfg_reg == 8'h00
        && blinkCfg_reg == 8'h00) else $error("reset did not clear");

    c_wrap_a: cover property (portalHit && index_reg == `LCB_BANK_A_LAST);
    c_blink_start: cover property (blinkEvent && !alternate);
    c_bank_switch: cover property (alternate && blinkTick && !bankB_reg);
    c_irq_rise: cover property ($rose(irq_reg));

endmodule : lcb_memory_access

// >>> verilog/lcb_defs.svh
// Purpose: Offsets, field positions, reset values and limits of the LCD memory access block
// Assumes: Byte-wide register port with a 12-bit address
// Notes: Included by bare name; definitions only
`ifndef LCB_DEFS_SVH
`define LCB_DEFS_SVH

// Register offsets
`define LCB_ADDR_INDEX 12'hfb1
`define LCB_ADDR_PORTAL 12'hfb2
`define LCB_ADDR_CLOCK 12'hfb3
`define LCB_ADDR_BLINK 12'hfb4
`define LCB_ADDR_MODE 12'hfb6
`define LCB_ADDR_STATUS 12'hfb8
`define LCB_ADDR_MASK 12'hfb9

// Reset values
`define LCB_RESET_BYTE 8'h00
`define LCB_RESET_INDEX 5'h00

// Index landmarks
`define LCB_BANK_A_LAST 5'h0b
`define LCB_BANK_B_FIRST 5'h10
`define LCB_BANK_B_LAST 5'h1b
`define LCB_BANK_BYTES 12
`define LCB_BANK_LAST_OFS 4'hb

// Field positions
`define LCB_INDEX_MSB 4
`define LCB_MODE_INTERRUPT_SOURCE_SELECT_BIT 2
`define LCB_ST_FRAME_BIT 0
`define LCB_ST_BLINK_BIT 1

// Reserved prescaler codes behave as the largest ratio
`define LCB_PRESCALE_MAX 3'h5

`endif

// >>> verilog/lcb_pkg.sv
// Purpose: Types shared by the LCD memory access block
// Assumes: Offsets and counts live in lcb_defs.svh
// Notes: Structs follow the register bit layout, MSB first
package lcb_pkg;

    // Blink selection codes
    typedef enum logic [1:0] {
        LCB_BLINK_NONE = 2'h0,
        LCB_BLINK_ONE = 2'h1,
        LCB_BLINK_COLUMN = 2'h2,
        LCB_BLINK_ALL = 2'h3
    } lcb_blink_e;

    // Display memory selection codes; both 1x codes alternate
    typedef enum logic [1:0] {
        LCB_DM_BANK_A = 2'h0,
        LCB_DM_BANK_B = 2'h1,
        LCB_DM_ALTERNATE = 2'h2,
        LCB_DM_ALTERNATE_2 = 2'h3
    } lcb_dm_e;

    // Clock configuration register layout
    typedef struct packed {
        logic clockSourceSelect;
        logic [2:0] prescaleCode;
        logic [3:0] frameDividerCode;
    } lcb_clk_cfg_s;

    // Blink control register layout
    typedef struct packed {
        logic [4:0] blinkDividerCode;
        lcb_blink_e blinkSelect;
        logic reserved;
    } lcb_blink_cfg_s;

endpackage : lcb_pkg

// >>> verilog/lcb_tick_divider.sv
// Purpose: Counts input steps and emits one tick every limit steps
// Assumes: limit is at least one
// Notes: A limit lowered to or below the steps already counted ends the period at the next step
`timescale 1ns/100ps

module lcb_tick_divider #(
    parameter int W = 7
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic step,
    input wire logic [W-1:0] limit,
    output logic tick
);

    // Steps seen in the current period
    logic [W-1:0] count_reg;

    // Compare with >= so a shrinking limit cannot strand the counter
    assign tick = step && (count_reg >= (limit - W'(1)));

    // Period counter
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            count_reg <= '0;
        end else if (tick) begin
            count_reg <= '0;
        end else if (step) begin
            count_reg <= count_reg + W'(1);
        end
    end

endmodule : lcb_tick_divider

// >>> tb/lcb_scan_model.sv
// Purpose: Waveform generator side model that scans the twelve display bytes
// Assumes: segByte answers segByteAddr one cycle later
// Notes: Keeps the last byte seen at every address for the bench to inspect
`timescale 1ns/100ps

module lcb_scan_model (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [7:0] segByte,
    output logic [3:0] segByteAddr
);
    // Last byte captured per address
    logic [7:0] shown [12];
    // Address whose answer arrives now
    logic [3:0] prevAddr;

    // Scan 0..11 without pause, as the pattern generator would
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            segByteAddr <= 4'h0;
            prevAddr <= 4'h0;
        end else begin
            segByteAddr <= (segByteAddr == 4'hb) ? 4'h0 : segByteAddr + 4'h1;
            prevAddr <= segByteAddr;
            // Capture lags the request by one registered stage
            if (prevAddr < 4'hc) begin
                shown[prevAddr] <= segByte;
            end
        end
    end
endmodule : lcb_scan_model

// >>> tb/lcd_clock_blink_memory_access_tb.sv
// Purpose: Self-checking bench for the LCD memory window, clock chain and blink
// Assumes: Register port with one-cycle strobes and read data one cycle later
// Notes: Frame periods are measured between two frameEnd pulses
`timescale 1ns/100ps
`include "lcb_defs.svh"

module lcd_clock_blink_memory_access_tb;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic [11:0] regAddr = 12'h000;
    logic [7:0] regWdata = 8'h00;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    logic [7:0] regRdata;
    logic watchTimerOutput = 1'b0;
    logic [3:0] segByteAddr;
    logic [7:0] segByte;
    logic frameEnd, blinkOff, bankBActive, irq;
    // Verdict counters
    int numErrors = 0;
    int totalChecks = 0;
    logic [7:0] rdVal;
    int n;
    // Enables the watch timer stimulus
    logic runWto = 1'b0;

    always #25 clk_sys = ~clk_sys;

    // Watch timer level toggles each cycle: one rising edge per two cycles
    always @(posedge clk_sys) watchTimerOutput <= runWto ? ~watchTimerOutput : 1'b0;

    lcb_memory_access i_dut (.clk_sys(clk_sys), .rst(rst), .regAddr(regAddr), .regWdata(regWdata),
        .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .watchTimerOutput(watchTimerOutput),
        .segByteAddr(segByteAddr), .segByte(segByte), .frameEnd(frameEnd), .blinkOff(blinkOff),
        .bankBActive(bankBActive), .irq(irq));

    lcb_scan_model i_panel (.clk_sys(clk_sys), .rst(rst), .segByte(segByte), .segByteAddr(segByteAddr));

    // Compare and count; unknowns never match
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        totalChecks++;
        if (got !== exp) begin
            numErrors++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk

    // Verdict and end of run
    task automatic tally_and_finish();
        $display("Checks %0d, mismatches %0d", totalChecks, numErrors);
        if (numErrors == 0 && totalChecks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : tally_and_finish

    // One-cycle write strobe
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        regAddr <= a;
        regWdata <= d;
        regWr <= 1'b1;
        @(posedge clk_sys);
        regWr <= 1'b0;
    endtask : wr

    // Read strobe; data taken in the following cycle only
    task automatic rd(input logic [11:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge clk_sys);
        regRd <= 1'b0;
        #1;
        d = regRdata;
    endtask : rd

    // Output selector for the bounded wait
    function automatic logic sig(input int w);
        case (w)
            0: return frameEnd;
            1: return blinkOff;
            2: return bankBActive;
            default: return irq;
        endcase
    endfunction : sig

    // Bounded wait for a level; running out ends the run
    task automatic waitSig(input int w, input logic lvl, output int c);
        for (c = 1; c <= 3000; c++) begin
            @(posedge clk_sys);
            #1;
            if (sig(w) === lvl) return;
        end
        numErrors++;
        $display("Error at %0t: wait on output %0d ran out", $time, w);
        tally_and_finish();
    endtask : waitSig

    // Reset values and an unmapped address
    task automatic t_reset();
        for (int a = 12'hfb1; a <= 12'hfb5; a++) begin
            rd(a[11:0], rdVal);
            chk(rdVal, 8'h00, "reset value");
        end
        $display("Test reset done");
    endtask : t_reset

    // Index stepping, wraps, reserved slots and streaming
    task automatic t_index();
        wr(`LCB_ADDR_INDEX, 8'h15);
        rd(`LCB_ADDR_INDEX, rdVal);
        chk(rdVal, 8'h15, "index readback");
        wr(`LCB_ADDR_INDEX, 8'h0a);
        wr(`LCB_ADDR_PORTAL, 8'ha5);
        wr(`LCB_ADDR_PORTAL, 8'h5a);
        wr(`LCB_ADDR_PORTAL, 8'h3c);
        rd(`LCB_ADDR_INDEX, rdVal);
        chk(rdVal, 8'h01, "bank A wrap");
        wr(`LCB_ADDR_INDEX, 8'h0a);
        rd(`LCB_ADDR_PORTAL, rdVal);
        chk(rdVal, 8'ha5, "portal byte 10");
        rd(`LCB_ADDR_PORTAL, rdVal);
        chk(rdVal, 8'h5a, "portal byte 11");
        rd(`LCB_ADDR_PORTAL, rdVal);
        chk(rdVal, 8'h3c, "portal byte 0");
        wr(`LCB_ADDR_INDEX, 8'h1b);
        wr(`LCB_ADDR_PORTAL, 8'h77);
        rd(`LCB_ADDR_INDEX, rdVal);
        chk(rdVal, 8'h10, "bank B wrap");
        rd(`LCB_ADDR_PORTAL, rdVal);
        chk(rdVal, 8'h00, "bank B first byte");
        wr(`LCB_ADDR_INDEX, 8'h0c);
        wr(`LCB_ADDR_PORTAL, 8'hee);
        rd(`LCB_ADDR_INDEX, rdVal);
        chk(rdVal, 8'h0d, "reserved slot step");
        rd(`LCB_ADDR_PORTAL, rdVal);
        chk(rdVal, 8'h00, "reserved slot reads zero");
        // Fill bank A with bit 0 set so blink masks show
        wr(`LCB_ADDR_INDEX, 8'h00);
        for (int i = 0; i < 12; i++) wr(`LCB_ADDR_PORTAL, {i[3:0], 4'hf});
        repeat (16) @(posedge clk_sys);
        for (int i = 0; i < 12; i++) chk(i_panel.shown[i], {i[3:0], 4'hf}, "panel byte");
        $display("Test index done");
    endtask : t_index

    // Frame period for source, prescale and frame divider codes
    task automatic t_clock();
        // Code 0x60 is a reserved prescaler code and must act as the largest ratio
        logic [7:0] code [8] = '{8'h00, 8'h06, 8'h07, 8'h0f, 8'h10, 8'h50, 8'h80, 8'h60};
        int per [8] = '{8, 14, 16, 32, 16, 256, 16, 256};
        for (int i = 0; i < 8; i++) begin
            runWto <= code[i][7];
            wr(`LCB_ADDR_CLOCK, code[i]);
            waitSig(0, 1'b1, n);
            waitSig(0, 1'b1, n);
            waitSig(0, 1'b1, n);
            chk(n[7:0], per[i][7:0], "frame period");
            chk(n[15:8], per[i][15:8], "frame period high byte");
        end
        runWto <= 1'b0;
        wr(`LCB_ADDR_CLOCK, 8'h00);
        $display("Test clock done");
    endtask : t_clock

    // Blink periods and the three masking modes
    task automatic t_blink();
        logic [7:0] code [3] = '{8'h02, 8'h04, 8'h06};
        logic [7:0] b0 [3] = '{8'h0e, 8'h00, 8'h00};
        logic [7:0] b1 [3] = '{8'h1f, 8'h1f, 8'h00};
        // Reserved bit 0 is written as zero in every blink setting
        wr(`LCB_ADDR_BLINK, 8'h3e);
        waitSig(1, 1'b1, n);
        waitSig(1, 1'b0, n);
        chk(n[7:0], 8'h50, "blink divide by 10");
        for (int i = 0; i < 3; i++) begin
            wr(`LCB_ADDR_BLINK, code[i]);
            waitSig(1, 1'b0, n);
            waitSig(1, 1'b1, n);
            // Thirteen scan captures fall inside the sixteen-cycle off phase
            repeat (14) @(posedge clk_sys);
            #1;
            chk(i_panel.shown[0], b0[i], "masked byte 0");
            chk(i_panel.shown[1], b1[i], "masked byte 1");
            waitSig(1, 1'b0, n);
            // Off phase is two frames of eight cycles; fourteen already spent
            chk(n[7:0] + 8'h0e, 8'h10, "blink divide by 2");
        end
        $display("Test blink done");
    endtask : t_blink

    // Frame and blink interrupt through status, mask and source select
    task automatic t_irq();
        wr(`LCB_ADDR_MASK, 8'h01);
        wr(`LCB_ADDR_STATUS, 8'h03);
        waitSig(0, 1'b1, n);
        waitSig(3, 1'b1, n);
        chk((n <= 3) ? 8'h01 : 8'h00, 8'h01, "frame irq delay");
        rd(`LCB_ADDR_STATUS, rdVal);
        chk(rdVal & 8'h01, 8'h01, "frame status");
        wr(`LCB_ADDR_MODE, 8'h04);
        wr(`LCB_ADDR_MASK, 8'h02);
        waitSig(1, 1'b0, n);
        wr(`LCB_ADDR_STATUS, 8'h03);
        repeat (2) @(posedge clk_sys);
        #1;
        chk({7'h00, irq}, 8'h00, "irq cleared");
        waitSig(1, 1'b1, n);
        waitSig(3, 1'b1, n);
        chk((n <= 3) ? 8'h01 : 8'h00, 8'h01, "blink irq delay");
        $display("Test irq done");
    endtask : t_irq

    // Alternating banks: blink ignored, bank switch pace and event
    task automatic t_alt();
        wr(`LCB_ADDR_MODE, 8'h06);
        waitSig(2, 1'b1, n);
        // Clear the A to B event just seen; the B to A edge raises none
        wr(`LCB_ADDR_STATUS, 8'h03);
        repeat (12) @(posedge clk_sys);
        #1;
        chk(i_panel.shown[11], 8'h77, "bank B byte 11");
        waitSig(2, 1'b0, n);
        chk({7'h00, blinkOff}, 8'h00, "blink ignored");
        waitSig(2, 1'b1, n);
        chk(n[7:0], 8'h10, "bank A phase");
        waitSig(3, 1'b1, n);
        chk((n <= 3) ? 8'h01 : 8'h00, 8'h01, "bank switch irq");
        $display("Test alternate done");
    endtask : t_alt

    // Main sequence
    initial begin
        repeat (8) @(posedge clk_sys);
        rst <= 1'b0;
        t_reset();
        t_index();
        t_clock();
        t_blink();
        t_irq();
        t_alt();
        tally_and_finish();
    end
endmodule : lcd_clock_blink_memory_access_tb
